// File: common/nvc_params.svh
`ifndef NVC_PARAMS_SVH
`define NVC_PARAMS_SVH

// parameter identifiers
`define NVC_PRM_RESTORE      16'h0006
`define NVC_PRM_RELOAD       16'h0007
`define NVC_PRM_RESULT       16'h400f
`define NVC_PRM_CFG_BASE     16'h8000
`define NVC_PRM_SIGNATURE    16'h8000
`define NVC_PRM_REV_MAJOR    16'h8001
`define NVC_PRM_REV_MINOR    16'h8002
`define NVC_PRM_APP_REV      16'h8003
`define NVC_PRM_HW_VARIANT   16'h8004
`define NVC_PRM_USER_REV     16'h8005
`define NVC_PRM_PASSCODE     16'h8006

// store word indices
`define NVC_IDX_SIGNATURE    3'h0
`define NVC_IDX_REV_MAJOR    3'h1
`define NVC_IDX_REV_MINOR    3'h2
`define NVC_IDX_APP_REV      3'h3
`define NVC_IDX_HW_VARIANT   3'h4
`define NVC_IDX_USER_REV     3'h5
`define NVC_IDX_PASSCODE     3'h6
`define NVC_IDX_LAST         3'h6

// factory defaults
`define NVC_DEF_SIGNATURE    16'h0159
`define NVC_DEF_REV_MAJOR    16'h0001
`define NVC_DEF_REV_MINOR    16'h0000
`define NVC_DEF_APP_REV      16'h0000
`define NVC_DEF_HW_VARIANT   16'h0000
`define NVC_DEF_USER_REV     16'h0000
`define NVC_DEF_PASSCODE     16'h1111

// operation result codes
`define NVC_RC_OK            8'h00
`define NVC_RC_BAD_PID       8'h01
`define NVC_RC_READ_ONLY     8'h02
`define NVC_RC_WRITE_ONLY    8'h03
`define NVC_RC_BAD_PASSWORD  8'h07
`define NVC_RC_DRIVE_ON      8'h08

// parameter classes
`define NVC_CL_BAD           3'h0
`define NVC_CL_RO            3'h1
`define NVC_CL_RW            3'h2
`define NVC_CL_PW            3'h3
`define NVC_CL_RESULT        3'h4
`define NVC_CL_RESTORE       3'h5
`define NVC_CL_RELOAD        3'h6
`define NVC_CL_ZERO          3'h7

`endif

// File: common/nvc_pkg.sv
package nvc_pkg;

	// host parameter request
	typedef struct packed {
		logic        write;
		logic [15:0] parameter_identifier;
		logic [15:0] data;
		logic [15:0] password;
	} nvc_host_req_s;

	// host answer
	typedef struct packed {
		logic [15:0] data;
		logic [7:0]  code;
	} nvc_host_rsp_s;

	// one store word access
	typedef struct packed {
		logic        we;
		logic [2:0]  addr;
		logic [15:0] wdata;
	} nvc_ee_cmd_s;

	// active operating copy
	typedef struct packed {
		logic [15:0] signature;
		logic [15:0] rev_major;
		logic [15:0] rev_minor;
		logic [15:0] app_rev;
		logic [15:0] passcode;
	} nvc_active_cfg_s;

	typedef enum logic [6:0] {
		ST_HDR  = 7'h01,
		ST_MAJ  = 7'h02,
		ST_DEF  = 7'h04,
		ST_LOAD = 7'h08,
		ST_IDLE = 7'h10,
		ST_HRD  = 7'h20,
		ST_HWR  = 7'h40
	} nvc_state_e;

endpackage

// File: src/nvc_ee_port.sv
`timescale 1ns/1ps
// single word access to the external store, request held until acknowledged
module nvc_ee_port
	import nvc_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        reset_in,
	input  wire logic        start_in,
	input  wire nvc_ee_cmd_s cmd_in,
	output logic             done_out,
	output logic [15:0]      rdata_out,
	output logic             ee_req_out,
	output nvc_ee_cmd_s      ee_cmd_out,
	input  wire logic        ee_ack_in,
	input  wire logic [15:0] ee_rdata_in
);

	logic        req_ff;
	logic        nxt_req;
	nvc_ee_cmd_s cmd_ff;
	nvc_ee_cmd_s nxt_cmd;
	logic        done_ff;
	logic        nxt_done;
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;

	// request launch, hold and completion
	always_comb begin
		nxt_req   = req_ff;
		nxt_cmd   = cmd_ff;
		nxt_done  = 1'b0;
		nxt_rdata = rdata_ff;
		if (req_ff) begin
			if (ee_ack_in) begin
				nxt_req   = 1'b0;
				nxt_done  = 1'b1;
				nxt_rdata = ee_rdata_in;
			end
		end else if (start_in) begin
			nxt_req = 1'b1;
			nxt_cmd = cmd_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			req_ff   <= 1'b0;
			cmd_ff   <= '0;
			done_ff  <= 1'b0;
			rdata_ff <= 16'h0000;
		end else begin
			req_ff   <= nxt_req;
			cmd_ff   <= nxt_cmd;
			done_ff  <= nxt_done;
			rdata_ff <= nxt_rdata;
		end
	end

	assign ee_req_out = req_ff;
	assign ee_cmd_out = cmd_ff;
	assign done_out   = done_ff;
	assign rdata_out  = rdata_ff;

endmodule

// File: src/nvc_config_manager.sv
`timescale 1ns/1ps
`include "nvc_params.svh"
// Operation
// R1: parameters live in external store, served from there
// R2: writes touch store only, not active copy
// R3: reload while drive enabled ignored, error
// R4: restore while disabled rewrites all defaults
// R5: restore while drive enabled ignored, error
// R6: bad signature at reset rewrites defaults
// R7: major revision mismatch at startup rewrites defaults
// R8: minor revision mismatch never rewrites
// R9: major and minor revisions read-only, consecutive
// R10: signature read-only fixed constant
// R11: application revision defaults zero, password gated
// R12: hardware variant read-only, always reads zero
// R13: refused while running gives code 8
// R14: write to read-only rejected, code 2
// R15: gated access needs matching stored password
// R16: user revision freely writable, never used
// R17: startup copies store to active before ready
// R18: result code written after every operation
module nvc_config_manager
	import nvc_pkg::*;
(
	input  wire logic          clk_sys_in,
	input  wire logic          reset_in,
	input  wire logic          drive_enabled_in,
	input  wire logic          host_req_valid_in,
	input  wire nvc_host_req_s host_req_in,
	output logic               host_req_ready_out,
	output logic               host_rsp_valid_out,
	output nvc_host_rsp_s      host_rsp_out,
	output logic               cfg_ready_out,
	output nvc_active_cfg_s    active_cfg_out,
	output logic [7:0]         result_code_out,
	output logic               ee_req_out,
	output nvc_ee_cmd_s        ee_cmd_out,
	input  wire logic          ee_ack_in,
	input  wire logic [15:0]   ee_rdata_in
);

	// factory default for a store word
	function automatic logic [15:0] default_word(input logic [2:0] idx);
		case (idx)
			`NVC_IDX_SIGNATURE:  default_word = `NVC_DEF_SIGNATURE;
			`NVC_IDX_REV_MAJOR:  default_word = `NVC_DEF_REV_MAJOR;
			`NVC_IDX_REV_MINOR:  default_word = `NVC_DEF_REV_MINOR;
			`NVC_IDX_APP_REV:    default_word = `NVC_DEF_APP_REV;
			`NVC_IDX_HW_VARIANT: default_word = `NVC_DEF_HW_VARIANT;
			`NVC_IDX_USER_REV:   default_word = `NVC_DEF_USER_REV;
			`NVC_IDX_PASSCODE:   default_word = `NVC_DEF_PASSCODE;
			default:             default_word = 16'h0000;
		endcase
	endfunction

	// access class of a parameter identifier
	function automatic logic [2:0] id_class(input logic [15:0] ident);
		case (ident)
			`NVC_PRM_SIGNATURE,
			`NVC_PRM_REV_MAJOR,
			`NVC_PRM_REV_MINOR:  id_class = `NVC_CL_RO;  // see R9, see R10
			`NVC_PRM_HW_VARIANT: id_class = `NVC_CL_ZERO; // see R12
			`NVC_PRM_USER_REV:   id_class = `NVC_CL_RW;   // see R16
			`NVC_PRM_APP_REV,
			`NVC_PRM_PASSCODE:   id_class = `NVC_CL_PW;   // see R11
			`NVC_PRM_RESULT:     id_class = `NVC_CL_RESULT;
			`NVC_PRM_RESTORE:    id_class = `NVC_CL_RESTORE;
			`NVC_PRM_RELOAD:     id_class = `NVC_CL_RELOAD;
			default:             id_class = `NVC_CL_BAD;
		endcase
	endfunction

	nvc_state_e      state_ff;
	nvc_state_e      nxt_state;
	logic [2:0]      idx_ff;
	logic [2:0]      nxt_idx;
	logic            pend_ff;
	logic            nxt_pend;
	logic            host_op_ff;
	logic            nxt_host_op;
	nvc_host_req_s   req_ff;
	nvc_host_req_s   nxt_req;
	logic [7:0]      result_ff;
	logic [7:0]      nxt_result;
	logic            rsp_valid_ff;
	logic            nxt_rsp_valid;
	nvc_host_rsp_s   rsp_ff;
	nvc_host_rsp_s   nxt_rsp;
	logic            ready_ff;
	logic            nxt_ready;
	nvc_active_cfg_s active_ff;
	nvc_active_cfg_s nxt_active;
	logic [15:0]     mirror_ff [0:6];
	logic [15:0]     nxt_mirror [0:6];
	logic            ee_start;
	nvc_ee_cmd_s     ee_cmd;
	logic            ee_done;
	logic [15:0]     ee_rdata;
	logic [2:0]      req_class;
	logic            pw_ok;

	nvc_ee_port u_ee_port (
		.clk_sys_in  (clk_sys_in),
		.reset_in    (reset_in),
		.start_in    (ee_start),
		.cmd_in      (ee_cmd),
		.done_out    (ee_done),
		.rdata_out   (ee_rdata),
		.ee_req_out  (ee_req_out),
		.ee_cmd_out  (ee_cmd_out),
		.ee_ack_in   (ee_ack_in),
		.ee_rdata_in (ee_rdata_in)
	);

	// request decode and password check against stored passcode
	assign req_class = id_class(host_req_in.parameter_identifier);
	assign pw_ok     = (host_req_in.password == mirror_ff[`NVC_IDX_PASSCODE]); // see R15

	// sequencer: startup checks, default rewrite, load, host operations
	always_comb begin
		nxt_state     = state_ff;
		nxt_idx       = idx_ff;
		nxt_pend      = pend_ff;
		nxt_host_op   = host_op_ff;
		nxt_req       = req_ff;
		nxt_result    = result_ff;
		nxt_rsp_valid = 1'b0;
		nxt_rsp       = rsp_ff;
		nxt_ready     = ready_ff;
		nxt_active    = active_ff;
		for (int i = 0; i < 7; i++) begin
			nxt_mirror[i] = mirror_ff[i];
		end
		ee_start = 1'b0;
		ee_cmd   = '0;
		case (state_ff)
			// read signature word after every reset
			ST_HDR: begin
				ee_cmd.addr = `NVC_IDX_SIGNATURE;
				if (!pend_ff) begin
					ee_start = 1'b1;
					nxt_pend = 1'b1;
				end else if (ee_done) begin
					nxt_pend = 1'b0;
					nxt_idx  = 3'h0;
					if (ee_rdata != `NVC_DEF_SIGNATURE) begin
						nxt_state = ST_DEF; // see R6
					end else begin
						nxt_state = ST_MAJ;
					end
				end
			end
			// major revision compared, minor left alone
			ST_MAJ: begin
				ee_cmd.addr = `NVC_IDX_REV_MAJOR;
				if (!pend_ff) begin
					ee_start = 1'b1;
					nxt_pend = 1'b1;
				end else if (ee_done) begin
					nxt_pend = 1'b0;
					nxt_idx  = 3'h0;
					if (ee_rdata != `NVC_DEF_REV_MAJOR) begin
						nxt_state = ST_DEF; // see R7
					end else begin
						nxt_state = ST_LOAD; // see R8
					end
				end
			end
			// write every word with its factory default
			ST_DEF: begin
				ee_cmd.we    = 1'b1;
				ee_cmd.addr  = idx_ff;
				ee_cmd.wdata = default_word(idx_ff);
				if (!pend_ff) begin
					ee_start = 1'b1;
					nxt_pend = 1'b1;
				end else if (ee_done) begin
					nxt_pend            = 1'b0;
					nxt_mirror[idx_ff]  = default_word(idx_ff);
					nxt_idx             = idx_ff + 3'h1;
					if (idx_ff == `NVC_IDX_LAST) begin
						nxt_idx = 3'h0;
						if (host_op_ff) begin
							nxt_state     = ST_IDLE; // see R4
							nxt_host_op   = 1'b0;
							nxt_result    = `NVC_RC_OK;
							nxt_rsp       = '{data: 16'h0000, code: `NVC_RC_OK};
							nxt_rsp_valid = 1'b1;
						end else begin
							nxt_state = ST_LOAD;
						end
					end
				end
			end
			// read whole store, then copy into active variables
			ST_LOAD: begin
				ee_cmd.addr = idx_ff;
				if (!pend_ff) begin
					ee_start = 1'b1;
					nxt_pend = 1'b1;
				end else if (ee_done) begin
					nxt_pend           = 1'b0;
					nxt_mirror[idx_ff] = ee_rdata; // see R1
					nxt_idx            = idx_ff + 3'h1;
					if (idx_ff == `NVC_IDX_LAST) begin
						nxt_idx              = 3'h0;
						nxt_state            = ST_IDLE;
						nxt_ready            = 1'b1; // see R17
						nxt_active.signature = mirror_ff[`NVC_IDX_SIGNATURE];
						nxt_active.rev_major = mirror_ff[`NVC_IDX_REV_MAJOR];
						nxt_active.rev_minor = mirror_ff[`NVC_IDX_REV_MINOR];
						nxt_active.app_rev   = mirror_ff[`NVC_IDX_APP_REV];
						nxt_active.passcode  = ee_rdata;
						if (host_op_ff) begin
							nxt_host_op   = 1'b0;
							nxt_result    = `NVC_RC_OK;
							nxt_rsp       = '{data: 16'h0000, code: `NVC_RC_OK};
							nxt_rsp_valid = 1'b1;
						end
					end
				end
			end
			// accept and classify host requests
			ST_IDLE: begin
				if (host_req_valid_in) begin
					nxt_req       = host_req_in;
					nxt_rsp_valid = 1'b1;
					nxt_rsp.data  = 16'h0000;
					nxt_rsp.code  = `NVC_RC_OK;
					case (req_class)
						`NVC_CL_BAD: nxt_rsp.code = `NVC_RC_BAD_PID;
						`NVC_CL_ZERO: begin
							if (host_req_in.write) begin
								nxt_rsp.code = `NVC_RC_READ_ONLY; // see R14
							end
						end
						`NVC_CL_RESULT: begin
							if (host_req_in.write) begin
								nxt_rsp.code = `NVC_RC_READ_ONLY; // see R14
							end else begin
								nxt_rsp.data = {8'h00, result_ff};
							end
						end
						`NVC_CL_RESTORE,
						`NVC_CL_RELOAD: begin
							if (!host_req_in.write) begin
								nxt_rsp.code = `NVC_RC_WRITE_ONLY;
							end else if (drive_enabled_in) begin
								nxt_rsp.code = `NVC_RC_DRIVE_ON; // see R3, see R5, see R13
							end else begin
								nxt_rsp_valid = 1'b0;
								nxt_host_op   = 1'b1;
								nxt_idx       = 3'h0;
								nxt_state     = (req_class == `NVC_CL_RESTORE) ? ST_DEF : ST_LOAD; // see R4
							end
						end
						`NVC_CL_RO: begin
							if (host_req_in.write) begin
								nxt_rsp.code = `NVC_RC_READ_ONLY; // see R14
							end else begin
								nxt_rsp_valid = 1'b0;
								nxt_state     = ST_HRD;
							end
						end
						default: begin
							if (req_class == `NVC_CL_PW && !pw_ok) begin
								nxt_rsp.code = `NVC_RC_BAD_PASSWORD; // see R11, see R15
							end else begin
								nxt_rsp_valid = 1'b0;
								nxt_state     = host_req_in.write ? ST_HWR : ST_HRD;
							end
						end
					endcase
					if (nxt_rsp_valid) begin
						nxt_result = nxt_rsp.code; // see R18
					end
				end
			end
			// parameter read from the store
			ST_HRD: begin
				ee_cmd.addr = req_ff.parameter_identifier[2:0];
				if (!pend_ff) begin
					ee_start = 1'b1;
					nxt_pend = 1'b1;
				end else if (ee_done) begin
					nxt_pend      = 1'b0;
					nxt_state     = ST_IDLE;
					nxt_result    = `NVC_RC_OK; // see R18
					nxt_rsp       = '{data: ee_rdata, code: `NVC_RC_OK};
					nxt_rsp_valid = 1'b1;
				end
			end
			// parameter write to the store, active copy untouched
			ST_HWR: begin
				ee_cmd.we    = 1'b1;
				ee_cmd.addr  = req_ff.parameter_identifier[2:0];
				ee_cmd.wdata = req_ff.data;
				if (!pend_ff) begin
					ee_start = 1'b1;
					nxt_pend = 1'b1;
				end else if (ee_done) begin
					nxt_pend                     = 1'b0;
					nxt_mirror[req_ff.parameter_identifier[2:0]] = req_ff.data; // see R2
					nxt_state                    = ST_IDLE;
					nxt_result                   = `NVC_RC_OK; // see R18
					nxt_rsp                      = '{data: 16'h0000, code: `NVC_RC_OK};
					nxt_rsp_valid                = 1'b1;
				end
			end
			default: begin
				nxt_state = ST_HDR;
				nxt_pend  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			state_ff     <= ST_HDR;
			idx_ff       <= 3'h0;
			pend_ff      <= 1'b0;
			host_op_ff   <= 1'b0;
			req_ff       <= '0;
			result_ff    <= `NVC_RC_OK;
			rsp_valid_ff <= 1'b0;
			rsp_ff       <= '0;
			ready_ff     <= 1'b0;
			active_ff    <= '0;
			for (int i = 0; i < 7; i++) begin
				mirror_ff[i] <= 16'h0000;
			end
		end else begin
			state_ff     <= nxt_state;
			idx_ff       <= nxt_idx;
			pend_ff      <= nxt_pend;
			host_op_ff   <= nxt_host_op;
			req_ff       <= nxt_req;
			result_ff    <= nxt_result;
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_ff       <= nxt_rsp;
			ready_ff     <= nxt_ready;
			active_ff    <= nxt_active;
			for (int i = 0; i < 7; i++) begin
				mirror_ff[i] <= nxt_mirror[i];
			end
		end
	end

	// outputs
	assign host_req_ready_out = (state_ff == ST_IDLE);
	assign host_rsp_valid_out = rsp_valid_ff;
	assign host_rsp_out       = rsp_ff;
	assign cfg_ready_out      = ready_ff;
	assign active_cfg_out     = active_ff;
	assign result_code_out    = result_ff;

endmodule

// File: tb/nvc_ee_model.sv
`timescale 1ns/1ps
// external store, wakes up blank, answers after lat_in extra cycles
module nvc_ee_model
	import nvc_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        req_in,
	input  wire nvc_ee_cmd_s cmd_in,
	input  wire logic [1:0]  lat_in,
	output logic             ack_out,
	output logic [15:0]      rdata_out
);
	logic [15:0] mem [8];
	logic [1:0]  wait_ff;

	// blank part before first programming
	initial begin
		foreach (mem[i]) mem[i] = 16'hffff;
		ack_out = 1'b0;
		rdata_out = 16'h0000;
		wait_ff = 2'h0;
	end

	// one word per request, data line toggles when not valid
	always @(posedge clk_sys_in) begin
		ack_out <= 1'b0;
		rdata_out <= ~rdata_out;
		if (req_in && !ack_out) begin
			if (wait_ff < lat_in) begin
				wait_ff <= wait_ff + 2'h1;
			end else begin
				wait_ff <= 2'h0;
				ack_out <= 1'b1;
				if (cmd_in.we) mem[cmd_in.addr] <= cmd_in.wdata;
				else rdata_out <= mem[cmd_in.addr];
			end
		end
	end
endmodule

// File: tb/nvc_config_manager_sva.sv
`timescale 1ns/1ps
// port level checks of the configuration manager
module nvc_config_manager_sva
	import nvc_pkg::*;
(
	input wire logic            clk_sys_in,
	input wire logic            reset_in,
	input wire logic            drive_enabled_in,
	input wire logic            host_req_valid_in,
	input wire nvc_host_req_s   host_req_in,
	input wire logic            host_req_ready_out,
	input wire logic            host_rsp_valid_out,
	input wire nvc_host_rsp_s   host_rsp_out,
	input wire logic            cfg_ready_out,
	input wire nvc_active_cfg_s active_cfg_out,
	input wire logic [7:0]      result_code_out,
	input wire logic            ee_req_out,
	input wire nvc_ee_cmd_s     ee_cmd_out,
	input wire logic            ee_ack_in
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	logic        take;
	logic [15:0] req_id;

	// request accepted this edge
	assign take   = host_req_valid_in && host_req_ready_out;
	assign req_id = host_req_in.parameter_identifier;

	AST_START_SIG: assert property ($fell(reset_in) |-> ##[0:2] ee_req_out && !ee_cmd_out.we && ee_cmd_out.addr == 3'h0)
		else $error("startup does not read signature first");
	AST_EE_HOLD: assert property (ee_req_out && !ee_ack_in |=> ee_req_out && $stable(ee_cmd_out))
		else $error("store request dropped or changed");
	AST_EE_DROP: assert property (ee_req_out && ee_ack_in |=> !ee_req_out)
		else $error("store request held after ack");
	AST_RO_WRITE: assert property (take && host_req_in.write
		&& req_id inside {16'h8000, 16'h8001, 16'h8002, 16'h8004, 16'h400f}
		|=> host_rsp_valid_out && host_rsp_out.code == 8'h02 && result_code_out == 8'h02)
		else $error("read only write not refused");
	AST_DRIVE_ON: assert property (take && host_req_in.write && drive_enabled_in
		&& req_id inside {16'h0006, 16'h0007} |=> host_rsp_valid_out && host_rsp_out.code == 8'h08 && !ee_req_out)
		else $error("command run while drive on");
	AST_HW_ZERO: assert property (take && !host_req_in.write && req_id == 16'h8004
		|=> host_rsp_valid_out && host_rsp_out.data == 16'h0000 && host_rsp_out.code == 8'h00)
		else $error("hardware word not zero");
	AST_ACTIVE_HOLD: assert property (ee_req_out && ee_ack_in && ee_cmd_out.we |=> $stable(active_cfg_out))
		else $error("active copy changed by store write");
	AST_LOAD_VALID: assert property ($rose(cfg_ready_out) |-> active_cfg_out.signature == 16'h0159
		&& active_cfg_out.rev_major == 16'h0001)
		else $error("ready with invalid active copy");
	AST_ANSWER: assert property (take |-> ##[1:150] host_rsp_valid_out)
		else $error("no answer to request");
	AST_RSP_PULSE: assert property (host_rsp_valid_out && !take |=> !host_rsp_valid_out)
		else $error("answer longer than one cycle");
	AST_EARLY_READY: assert property (!cfg_ready_out |-> !host_req_ready_out)
		else $error("requests accepted before startup done");
endmodule

bind nvc_config_manager nvc_config_manager_sva chk_u (.*);

// File: tb/nvc_config_manager_tb.sv
`timescale 1ns/1ps
module nvc_config_manager_tb
	import nvc_pkg::*;
;
	logic            clk_sys_in = 1'b0;
	logic            reset_in = 1'b1;
	logic            drive_enabled_in = 1'b0;
	logic            host_req_valid_in = 1'b0;
	nvc_host_req_s   host_req_in = '0;
	logic            host_req_ready_out, host_rsp_valid_out, cfg_ready_out, ee_req_out, ee_ack_in;
	nvc_host_rsp_s   host_rsp_out;
	nvc_active_cfg_s active_cfg_out;
	logic [7:0]      result_code_out;
	nvc_ee_cmd_s     ee_cmd_out;
	logic [15:0]     ee_rdata_in;
	logic [15:0]     rnd = 16'ha376;
	logic [1:0]      lat = 2'h0;
	logic [24:0]     exp_q[$];
	logic [24:0]     e;
	logic [15:0]     def_w [7] = '{16'h0159, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h1111};
	logic [15:0]     ro_w [5] = '{16'h8000, 16'h8001, 16'h8002, 16'h8004, 16'h400f};
	int              err_total = 0;
	int              compares = 0;
	int              cyc = 0;

	always #2.5 clk_sys_in = ~clk_sys_in;

	nvc_config_manager dut_u (.clk_sys_in, .reset_in, .drive_enabled_in, .host_req_valid_in, .host_req_in,
		.host_req_ready_out, .host_rsp_valid_out, .host_rsp_out, .cfg_ready_out, .active_cfg_out,
		.result_code_out, .ee_req_out, .ee_cmd_out, .ee_ack_in, .ee_rdata_in);
	nvc_ee_model ee_u (.clk_sys_in, .req_in(ee_req_out), .cmd_in(ee_cmd_out), .lat_in(lat),
		.ack_out(ee_ack_in), .rdata_out(ee_rdata_in));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		compares++;
		if (got !== want) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	task automatic give_verdict();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// wait until the block accepts requests again
	task automatic idle();
		@(negedge clk_sys_in);
		while (host_req_ready_out !== 1'b1) @(negedge clk_sys_in);
	endtask

	// one host request, expectation noted first; data checked on good reads
	task automatic op(input logic wr, input logic [15:0] ident, input logic [15:0] dat, input logic [15:0] pw,
		input logic [15:0] want, input logic [7:0] code);
		idle();
		exp_q.push_back({!wr && code == 8'h00, want, code});
		@(posedge clk_sys_in);
		rnd = lfsr(rnd);
		lat <= rnd[1:0];
		host_req_valid_in <= 1'b1;
		host_req_in <= '{wr, ident, dat, pw};
		@(posedge clk_sys_in);
		host_req_valid_in <= 1'b0;
	endtask

	// reset, poke a request during startup, wait for ready
	task automatic boot();
		@(posedge clk_sys_in);
		reset_in <= 1'b1;
		repeat (16) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		host_req_valid_in <= 1'b1;
		host_req_in <= '{1'b1, 16'h8005, 16'h5a5a, 16'h1111};
		@(posedge clk_sys_in);
		host_req_valid_in <= 1'b0;
		while (cfg_ready_out !== 1'b1) @(negedge clk_sys_in);
	endtask

	// answer watcher and hang limit
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc > 5000) begin
			err_total++;
			give_verdict();
		end else if (host_rsp_valid_out === 1'b1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 25'h0ffffff;
			chk({8'h00, host_rsp_out.code}, {8'h00, e[7:0]});
			chk({8'h00, result_code_out}, {8'h00, e[7:0]});
			if (e[24]) chk(host_rsp_out.data, e[23:8]);
		end
	end

	initial begin
		logic [15:0] v;
		boot();
		for (int i = 0; i < 7; i++) chk(ee_u.mem[i], def_w[i]);
		for (int i = 0; i < 4; i++) chk(active_cfg_out[79-16*i -: 16], def_w[i]);
		chk(active_cfg_out.passcode, 16'h1111);
		for (int i = 0; i < 7; i++) op(1'b0, 16'h8000 + 16'(i), 16'h0, 16'h1111, def_w[i], 8'h00);
		foreach (ro_w[i]) op(1'b1, ro_w[i], 16'hffff, 16'h1111, 16'h0, 8'h02);
		op(1'b0, 16'h400f, 16'h0, 16'h1111, 16'h0002, 8'h00);
		op(1'b0, 16'h8000, 16'h0, 16'h1111, 16'h0159, 8'h00);
		op(1'b0, 16'h8003, 16'h0, 16'h1110, 16'h0, 8'h07);
		op(1'b1, 16'h8006, 16'h2222, 16'h0000, 16'h0, 8'h07);
		op(1'b0, 16'h1234, 16'h0, 16'h1111, 16'h0, 8'h01);
		op(1'b0, 16'h0007, 16'h0, 16'h1111, 16'h0, 8'h03);
		rnd = lfsr(rnd);
		v = rnd;
		op(1'b1, 16'h8005, v, 16'h1111, 16'h0, 8'h00);
		op(1'b0, 16'h8005, 16'h0, 16'h1111, v, 8'h00);
		op(1'b1, 16'h8003, ~v, 16'h1111, 16'h0, 8'h00);
		op(1'b0, 16'h8003, 16'h0, 16'h1111, ~v, 8'h00);
		drive_enabled_in <= 1'b1;
		op(1'b1, 16'h0007, 16'h0001, 16'h1111, 16'h0, 8'h08);
		op(1'b1, 16'h0006, 16'h0001, 16'h1111, 16'h0, 8'h08);
		idle();
		chk(ee_u.mem[3], ~v);
		chk(active_cfg_out.app_rev, 16'h0000);
		@(posedge clk_sys_in);
		drive_enabled_in <= 1'b0;
		op(1'b1, 16'h0007, 16'h0001, 16'h1111, 16'h0, 8'h00);
		idle();
		chk(active_cfg_out.app_rev, ~v);
		op(1'b1, 16'h0006, 16'h0001, 16'h1111, 16'h0, 8'h00);
		idle();
		for (int i = 0; i < 7; i++) chk(ee_u.mem[i], def_w[i]);
		ee_u.mem[1] = 16'h0002;
		ee_u.mem[5] = 16'h4321;
		boot();
		chk(ee_u.mem[5], 16'h0000);
		chk(active_cfg_out.rev_major, 16'h0001);
		ee_u.mem[2] = 16'h0005;
		ee_u.mem[5] = v;
		boot();
		chk(active_cfg_out.rev_minor, 16'h0005);
		op(1'b0, 16'h8005, 16'h0, 16'h1111, v, 8'h00);
		idle();
		repeat (2) @(negedge clk_sys_in);
		chk(16'(exp_q.size()), 16'h0000);
		give_verdict();
	end
endmodule
